// ==== inc/dft_defines.svh ====
`ifndef DFT_DEFINES_SVH
`define DFT_DEFINES_SVH

// Register byte addresses
`define DFT_GEN_CFG_ADDR 32'h0000_8300
`define DFT_OUT_CFG_ADDR 32'h0000_8304
`define DFT_STATUS_ADDR 32'h0000_8308
`define DFT_PIX_PORT_ADDR 32'h0000_8378
`define DFT_CMP_PORT_ADDR 32'h0000_837C

// Field positions, general_display_configuration
`define DFT_GEN_TEST_BIT 0
`define DFT_GEN_LOAD_BIT 1
// Field positions, output_configuration
`define DFT_OUT_TEST_BIT 0
`define DFT_OUT_RSEL_BIT 1
// Field positions, status
`define DFT_ST_PWPTR_LSB 0
`define DFT_ST_PRPTR_LSB 4
`define DFT_ST_CWPTR_LSB 8
`define DFT_ST_CRPTR_LSB 12
`define DFT_ST_PPRIME_BIT 16
`define DFT_ST_CPRIME_BIT 17
`define DFT_ST_PWHALF_BIT 18
`define DFT_ST_PRHALF_BIT 19

// Reset values
`define DFT_GEN_RESET 2'h2
`define DFT_OUT_RESET 2'h0
`define DFT_ZERO32 32'h0000_0000

// Fifo geometry
`define DFT_PIX_DEPTH 8
`define DFT_PIX_AW 3
`define DFT_CMP_DEPTH 16
`define DFT_CMP_AW 4

// Transfer type bit that marks NONSEQ or SEQ
`define DFT_HTRANS_ACTIVE_BIT 1

`endif

// ==== inc/dft_pkg.sv ====
package dft_pkg;

  typedef enum logic [2:0]
  {
    DFT_SEL_NONE,
    DFT_SEL_GEN,
    DFT_SEL_OUT,
    DFT_SEL_STATUS,
    DFT_SEL_PIX,
    DFT_SEL_CMP
  } dft_sel_t;

  typedef struct packed
  {
    logic test_access_enable;
    logic display_fifo_load_enable;
    logic out_test_enable;
    logic compressed_fifo_read_select;
  } dft_cfg_t;

endpackage

// ==== hdl/dft_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Pixel entries are 64 bits; two port writes fill one entry.
// - Pixel write pointer steps after every second pixel port write.
// - One ignored read after writing loads the pixel output latch.
// - After priming, reads of either port return written data in order.
// - Pixel read pointer steps after every second pixel port read.
// - Compressed write pointer steps after every compressed port write made with read select low.
// - Read select high enables compressed reads; one ignored read primes latch.
// - Compressed read pointer steps after every compressed port read.
`include "dft_defines.svh"

module dft_top
  import dft_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  // ****************************************
  // Address decode
  // ****************************************
  function automatic dft_sel_t addr_sel(input logic [31:0] a);
    case (a)
      `DFT_GEN_CFG_ADDR: addr_sel = DFT_SEL_GEN;
      `DFT_OUT_CFG_ADDR: addr_sel = DFT_SEL_OUT;
      `DFT_STATUS_ADDR: addr_sel = DFT_SEL_STATUS;
      `DFT_PIX_PORT_ADDR: addr_sel = DFT_SEL_PIX;
      `DFT_CMP_PORT_ADDR: addr_sel = DFT_SEL_CMP;
      default: addr_sel = DFT_SEL_NONE;
    endcase
  endfunction
  dft_cfg_t cfg_reg;
  dft_sel_t wsel_reg, asel;
  logic acc, pix_en, cmp_wen, cmp_ren;
  logic rd_pix, rd_cmp, wr_pix, wr_cmp;
  // Transfer size is ignored: only whole words are expected
  assign acc = hsel & hready & htrans[`DFT_HTRANS_ACTIVE_BIT];
  assign asel = addr_sel(haddr);
  assign pix_en = cfg_reg.test_access_enable & ~cfg_reg.display_fifo_load_enable;
  assign cmp_wen = pix_en & cfg_reg.out_test_enable & ~cfg_reg.compressed_fifo_read_select;
  assign cmp_ren = pix_en & cfg_reg.out_test_enable & cfg_reg.compressed_fifo_read_select;
  assign rd_pix = acc & ~hwrite & (asel == DFT_SEL_PIX) & pix_en;
  assign rd_cmp = acc & ~hwrite & (asel == DFT_SEL_CMP) & cmp_ren;
  assign wr_pix = (wsel_reg == DFT_SEL_PIX) & pix_en;
  assign wr_cmp = (wsel_reg == DFT_SEL_CMP) & cmp_wen;
  // Write effects land in the data phase, one edge after the address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wsel_reg <= DFT_SEL_NONE;
    else
      wsel_reg <= (acc & hwrite) ? asel : DFT_SEL_NONE;
  end
  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg.test_access_enable <= 1'(`DFT_GEN_RESET >> `DFT_GEN_TEST_BIT);
      cfg_reg.display_fifo_load_enable <= 1'(`DFT_GEN_RESET >> `DFT_GEN_LOAD_BIT);
      cfg_reg.out_test_enable <= 1'(`DFT_OUT_RESET >> `DFT_OUT_TEST_BIT);
      cfg_reg.compressed_fifo_read_select <= 1'(`DFT_OUT_RESET >> `DFT_OUT_RSEL_BIT);
    end
    else if (wsel_reg == DFT_SEL_GEN)
    begin
      cfg_reg.test_access_enable <= hwdata[`DFT_GEN_TEST_BIT];
      cfg_reg.display_fifo_load_enable <= hwdata[`DFT_GEN_LOAD_BIT];
    end
    else if (wsel_reg == DFT_SEL_OUT)
    begin
      cfg_reg.out_test_enable <= hwdata[`DFT_OUT_TEST_BIT];
      cfg_reg.compressed_fifo_read_select <= hwdata[`DFT_OUT_RSEL_BIT];
    end
  end

  // ****************************************
  // Pixel fifo, 64-bit entries
  // ****************************************
  logic [63:0] pmem [`DFT_PIX_DEPTH];
  logic [`DFT_PIX_AW-1:0] pwptr, prptr;
  logic [31:0] pw_low;
  logic [63:0] p_latch;
  logic pw_half, p_primed, p_rhalf;
  always_ff @(posedge hclk)
  begin
    if (wr_pix & pw_half)
      pmem[pwptr] <= {hwdata, pw_low};
  end
  // First write of a pair is the low word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwptr <= '0;
      pw_low <= `DFT_ZERO32;
      pw_half <= 1'b0;
    end
    else if (wr_pix)
    begin
      if (pw_half)
      begin
        pwptr <= pwptr + 1'b1;
        pw_half <= 1'b0;
      end
      else
      begin
        pw_low <= hwdata;
        pw_half <= 1'b1;
      end
    end
  end

  // Reload of the latch lands on the read's own edge, so back-to-back reads need no gap
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prptr <= '0;
      p_latch <= '0;
      p_primed <= 1'b0;
      p_rhalf <= 1'b0;
    end
    else if (wr_pix)
      p_primed <= 1'b0;
    else if (rd_pix)
    begin
      if (!p_primed)
      begin
        p_latch <= pmem[prptr];
        p_primed <= 1'b1;
        p_rhalf <= 1'b0;
      end
      else if (p_rhalf)
      begin
        prptr <= prptr + 1'b1;
        p_latch <= pmem[prptr + 1'b1];
        p_rhalf <= 1'b0;
      end
      else
        p_rhalf <= 1'b1;
    end
  end

  // ****************************************
  // Compressed fifo, 32-bit entries
  // ****************************************
  logic [31:0] cmem [`DFT_CMP_DEPTH];
  logic [`DFT_CMP_AW-1:0] cwptr, crptr;
  logic [31:0] c_latch;
  logic c_primed;
  always_ff @(posedge hclk)
  begin
    if (wr_cmp)
      cmem[cwptr] <= hwdata;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cwptr <= '0;
    else if (wr_cmp)
      cwptr <= cwptr + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      crptr <= '0;
      c_latch <= `DFT_ZERO32;
      c_primed <= 1'b0;
    end
    else if (wr_cmp)
      c_primed <= 1'b0;
    else if (rd_cmp)
    begin
      if (!c_primed)
      begin
        c_latch <= cmem[crptr];
        c_primed <= 1'b1;
      end
      else
      begin
        crptr <= crptr + 1'b1;
        c_latch <= cmem[crptr + 1'b1];
      end
    end
  end

  // ****************************************
  // Read data and response
  // ****************************************
  logic [31:0] rdata_next;
  always_comb
  begin
    rdata_next = `DFT_ZERO32;
    case (asel)
      DFT_SEL_GEN:
      begin
        rdata_next[`DFT_GEN_TEST_BIT] = cfg_reg.test_access_enable;
        rdata_next[`DFT_GEN_LOAD_BIT] = cfg_reg.display_fifo_load_enable;
      end
      DFT_SEL_OUT:
      begin
        rdata_next[`DFT_OUT_TEST_BIT] = cfg_reg.out_test_enable;
        rdata_next[`DFT_OUT_RSEL_BIT] = cfg_reg.compressed_fifo_read_select;
      end
      DFT_SEL_STATUS:
      begin
        rdata_next[`DFT_ST_PWPTR_LSB +: `DFT_PIX_AW] = pwptr;
        rdata_next[`DFT_ST_PRPTR_LSB +: `DFT_PIX_AW] = prptr;
        rdata_next[`DFT_ST_CWPTR_LSB +: `DFT_CMP_AW] = cwptr;
        rdata_next[`DFT_ST_CRPTR_LSB +: `DFT_CMP_AW] = crptr;
        rdata_next[`DFT_ST_PPRIME_BIT] = p_primed;
        rdata_next[`DFT_ST_CPRIME_BIT] = c_primed;
        rdata_next[`DFT_ST_PWHALF_BIT] = pw_half;
        rdata_next[`DFT_ST_PRHALF_BIT] = p_rhalf;
      end
      DFT_SEL_PIX:
        if (rd_pix & p_primed)
          rdata_next = p_rhalf ? p_latch[63:32] : p_latch[31:0];
      DFT_SEL_CMP:
        if (rd_cmp & c_primed)
          rdata_next = c_latch;
      default:
        rdata_next = `DFT_ZERO32;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= `DFT_ZERO32;
    else if (acc & ~hwrite)
      hrdata <= rdata_next;
  end
  // Zero wait states: every access completes OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {hreadyout, hresp} <= 2'h0;
    else
      {hreadyout, hresp} <= 2'h2;
  end
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pix_prime;
    rd_pix && !p_primed;
  endsequence
  sequence s_pix_low_read;
    rd_pix && p_primed && !p_rhalf;
  endsequence
  sequence s_pix_high_read;
    rd_pix && p_primed && p_rhalf;
  endsequence
  chk_pix_half_hold: assert property (wr_pix && !pw_half |=> $stable(pwptr) && pw_half)
    else $error("pixel write pointer moved on first half");
  chk_pix_wptr_step: assert property (wr_pix && pw_half |=> pwptr == 3'($past(pwptr) + 1))
    else $error("pixel write pointer did not step");
  chk_pix_prime_load: assert property (s_pix_prime |=> p_primed && $stable(prptr) && hrdata == 0)
    else $error("priming read misbehaved");
  chk_pix_low_word: assert property (s_pix_low_read |=> hrdata == $past(p_latch[31:0]))
    else $error("pixel low word wrong");
  chk_pix_read_order: assert property (s_pix_high_read |=> hrdata == $past(p_latch[63:32]))
    else $error("pixel high word wrong");
  chk_pix_rptr_pair: assert property (s_pix_high_read |=> prptr == 3'($past(prptr) + 1))
    else $error("pixel read pointer did not step");
  chk_cmp_wptr_step: assert property (wr_cmp |=> cwptr == 4'($past(cwptr) + 1))
    else $error("compressed write pointer did not step");
  chk_cmp_read_gate: assert property (acc && !hwrite && asel == DFT_SEL_CMP && !cmp_ren
    |=> hrdata == 0 && $stable(crptr))
    else $error("compressed read without read select");
  chk_cmp_rptr_step: assert property (rd_cmp && c_primed
    |=> crptr == 4'($past(crptr) + 1) && hrdata == $past(c_latch))
    else $error("compressed read pointer did not step");
  chk_ptr_wrap: assert property (wr_cmp && cwptr == 4'hF |=> cwptr == 4'h0)
    else $error("compressed write pointer did not wrap");
endmodule

// ==== verification/dft_top_bench.sv ====
`timescale 1ns/1ps
`include "dft_defines.svh"

module dft_top_bench
  import dft_pkg::*;
;
  // ****
  // Signals and model state
  // ****
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic [31:0] pq[$];
  logic [31:0] cq[$];
  logic pprime = 1'b0;
  logic cprime = 1'b0;
  int pwn = 0;
  int prn = 0;
  int cwn = 0;
  int crn = 0;
  int fail_count = 0;
  int cmp_count = 0;

  initial
  begin
    forever #5 hclk = ~hclk;
  end

  dft_top i_dut
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata)
  );

  // ****
  // Bus and check tasks
  // ****
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  // Bounded wait, so a stuck slave ends the run instead of hanging it
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(name, q, exp);
    chk("hresp", {31'h0, hresp}, `DFT_ZERO32);
  endtask

  // Expected status word from the model's transfer counts
  function automatic logic [31:0] st();
    return {12'h000, prn[0], pwn[0], cprime, pprime, crn[3:0], cwn[3:0],
            1'b0, prn[3:1], 1'b0, pwn[3:1]};
  endfunction

  // ****
  // Tests
  // ****
  initial
  begin
    void'($urandom(82747));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd_chk("gen_cfg", `DFT_GEN_CFG_ADDR, 32'h0000_0002);
    rd_chk("out_cfg", `DFT_OUT_CFG_ADDR, 32'h0000_0000);
    wr(32'h0000_8310, 32'hFFFF_FFFF);
    rd_chk("unmapped", 32'h0000_8310, 32'h0000_0000);
    wr(`DFT_PIX_PORT_ADDR, 32'hA5A5_A5A5);
    wr(`DFT_CMP_PORT_ADDR, 32'h5A5A_5A5A);
    rd_chk("pix_refused", `DFT_PIX_PORT_ADDR, 32'h0000_0000);
    rd_chk("status", `DFT_STATUS_ADDR, st());
    $display("Test reset done");
    wr(`DFT_GEN_CFG_ADDR, 32'h0000_0001);
    for (int i = 0; i < 16; i++)
    begin
      d = $urandom();
      wr(`DFT_PIX_PORT_ADDR, d);
      pq.push_back(d);
      pwn++;
      pprime = 1'b0;
      if (i == 2)
        rd_chk("pix_status", `DFT_STATUS_ADDR, st());
    end
    rd_chk("pix_status", `DFT_STATUS_ADDR, st());
    rd_chk("pix_prime", `DFT_PIX_PORT_ADDR, 32'h0000_0000);
    pprime = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      // Shift time before each pixel read
      repeat (4) @(posedge hclk);
      rd_chk("pix_data", `DFT_PIX_PORT_ADDR, pq.pop_front());
      prn++;
      if (i == 2)
        rd_chk("pix_status", `DFT_STATUS_ADDR, st());
    end
    rd_chk("pix_status", `DFT_STATUS_ADDR, st());
    $display("Test pixel done");
    wr(`DFT_OUT_CFG_ADDR, 32'h0000_0001);
    rd_chk("cmp_refused", `DFT_CMP_PORT_ADDR, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
    begin
      d = $urandom();
      wr(`DFT_CMP_PORT_ADDR, d);
      cq.push_back(d);
      cwn++;
      if (i == 0)
        rd_chk("cmp_status", `DFT_STATUS_ADDR, st());
    end
    rd_chk("cmp_status", `DFT_STATUS_ADDR, st());
    wr(`DFT_OUT_CFG_ADDR, 32'h0000_0003);
    rd_chk("cmp_prime", `DFT_CMP_PORT_ADDR, 32'h0000_0000);
    cprime = 1'b1;
    // Back to back: this port needs no gap between reads
    for (int i = 0; i < 16; i++)
    begin
      rd_chk("cmp_data", `DFT_CMP_PORT_ADDR, cq.pop_front());
      crn++;
    end
    wr(`DFT_CMP_PORT_ADDR, 32'h1234_5678);
    rd_chk("cmp_status", `DFT_STATUS_ADDR, st());
    $display("Test compressed done");
    complete_run();
  end
endmodule
